/* File: logic/sio_pkg.sv */
// Package for the clock-synchronous serial port: mode field layout,
// reset values, divider ratios and the CPU-side operation bundle.
// Assumes a CPU core that issues one-cycle operation strobes.
package sio_pkg;
  localparam int MODE_W = 4;
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int CNT_W = 3;
  // Mode register field positions
  localparam int CLK_SRC_POS = 0;
  localparam int PIN_FN_POS = 1;
  localparam int CLK_DIV_POS = 2;
  localparam int SPARE_POS = 3;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  // Instruction clock dividers for the internal shift clock
  localparam int DIV_SLOW = 8;
  localparam int DIV_FAST = 4;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef struct packed {
    logic write_mode_from_acc;
    logic read_mode_to_acc;
    logic load_shift_from_accs;
    logic read_shift_to_accs;
    logic transfer_start_op;
    logic skip_if_transfer_done;
    logic irq_ack;
    logic [3:0] acc_a;
    logic [3:0] reg_b;
  } cpu_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b10
  } sio_state_t;
endpackage : sio_pkg

/* File: logic/clock_sync_serial_port.sv */
// Clock-synchronous 8-bit serial port with shift register, done flag,
// mode register and three shared input pins.
// Assumes instr_clk_en is a one-cycle pulse per instruction clock on mclk.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Divide bit: 0 gives /8, 1 gives /4
// - Pin bit selects plain inputs or serial pins
// - Clock source bit: 0 external, 1 internal
// - Spare mode bit stored and read back
// - Load shift register: A low, B high
// - LSB first out; input enters bit 7
// - Done flag set after eight bits
// - Flag cleared by interrupt or skip taken
// - Start clears flag then begins transfer
// - Mode written from A, read to A
// - External clock never gated; done after eight
// - Internal clock stops after transfer completes
// - Receiver ready line handshake via port bit
// - Mode resets to zero, kept in backup
// - Shared pins always readable as inputs
module clock_sync_serial_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Instruction clock enable and CPU operation strobes
  input wire logic instr_clk_en,
  input wire sio_pkg::cpu_op_t cpu_op,
  // Pin levels in, CPU read-back and pin drivers out
  input wire logic [2:0] shared_pin_in,
  output logic [3:0] acc_out,
  output logic [7:0] shift_out,
  output logic skip_taken,
  output logic transfer_done_flag,
  output logic [2:0] shared_input,
  output logic sck_out,
  output logic sck_oe,
  output logic sout_out,
  output logic sout_oe
);
  // Mode, shift and count state
  logic [3:0] mode_r;
  logic [7:0] shift_r;
  logic [2:0] cnt_r;
  logic [2:0] div_r;
  logic done_r;
  // Pin synchroniser stages
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic ext_prev_r;
  // Registered pin drivers and CPU answers
  logic sck_r;
  logic sout_r;
  logic [3:0] acc_r;
  logic skip_r;
  sio_pkg::sio_state_t st_r;

  // Mode decode
  wire internal_clk = mode_r[sio_pkg::CLK_SRC_POS];
  wire serial_pins = mode_r[sio_pkg::PIN_FN_POS];
  wire fast_div = mode_r[sio_pkg::CLK_DIV_POS];
  wire ext_sck = pin_s2_r[0];
  wire sin_bit = pin_s2_r[2];
  // Half-period tick of the divided clock
  // End points cast to the counter width on purpose
  wire [2:0] half_fast = 3'(sio_pkg::DIV_FAST / 2 - 1);
  wire [2:0] half_slow = 3'(sio_pkg::DIV_SLOW / 2 - 1);
  wire [2:0] half_last = fast_div ? half_fast : half_slow;
  wire half_tick = instr_clk_en && (div_r == half_last);
  wire int_fall = internal_clk && st_r == sio_pkg::ST_HIGH && half_tick;
  wire int_rise = internal_clk && st_r == sio_pkg::ST_LOW && half_tick;
  // External clock pin is only watched, never driven
  wire ext_mode = !internal_clk;
  wire ext_fall = ext_mode && ext_prev_r && !ext_sck;
  wire ext_rise = ext_mode && !ext_prev_r && ext_sck;
  wire fall_edge = int_fall || ext_fall;
  wire rise_edge = int_rise || ext_rise;
  wire active = st_r != sio_pkg::ST_IDLE;
  wire last_rise = active && rise_edge && cnt_r == sio_pkg::LAST_BIT;
  wire skip_now = cpu_op.skip_if_transfer_done && done_r;

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      // Pulled-up idle level, so no false edge after reset
      pin_s1_r <= 3'h7;
      pin_s2_r <= 3'h7;
      ext_prev_r <= 1'b1;
    end else begin
      pin_s1_r <= shared_pin_in;
      pin_s2_r <= pin_s1_r;
      ext_prev_r <= pin_s2_r[0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) shared_input <= 3'h0;
    else shared_input <= pin_s2_r;
  end

  // Mode register, reset to zero, no backup clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) mode_r <= sio_pkg::MODE_RST;
    // Written only from A; spare bit kept
    else if (cpu_op.write_mode_from_acc) mode_r <= cpu_op.acc_a;
  end

  // Divider restarts at each start so the first half-period is full
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) div_r <= 3'h0;
    else if (cpu_op.transfer_start_op || !active) div_r <= 3'h0;
    else if (half_tick) div_r <= 3'h0;
    else if (instr_clk_en) div_r <= div_r + 3'h1;
  end

  // Transfer sequencer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= sio_pkg::ST_IDLE;
      cnt_r <= 3'h0;
    end else if (cpu_op.transfer_start_op) begin
      // Start taken at any time, so a receiver can
      // arm first and only then lower its ready port bit
      st_r <= sio_pkg::ST_HIGH;
      cnt_r <= 3'h0;
    end else begin
      unique case (st_r)
        sio_pkg::ST_IDLE: st_r <= sio_pkg::ST_IDLE;
        sio_pkg::ST_HIGH: if (fall_edge) st_r <= sio_pkg::ST_LOW;
        sio_pkg::ST_LOW: begin
          // Count rising edges, eighth ends the transfer
          if (rise_edge) begin
            cnt_r <= cnt_r + 3'h1;
            // Internal clock stops after eighth pulse
            st_r <= (cnt_r == sio_pkg::LAST_BIT) ? sio_pkg::ST_IDLE : sio_pkg::ST_HIGH;
          end
        end
        default: st_r <= sio_pkg::ST_IDLE;
      endcase
    end
  end

  // Shift register: CPU load, or one bit per rising edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) shift_r <= sio_pkg::SHIFT_RST;
    // A into low nibble, B into high nibble
    else if (cpu_op.load_shift_from_accs) shift_r <= {cpu_op.reg_b, cpu_op.acc_a};
    // Shift right, input enters bit 7
    // External edges shift even past the eighth
    // the count alone decides when the flag is raised
    else if (rise_edge) shift_r <= {sin_bit, shift_r[7:1]};
  end

  // Serial data out changes on falling edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) sout_r <= 1'b1;
    else if (cpu_op.load_shift_from_accs) sout_r <= cpu_op.acc_a[0];
    // External falls keep moving data out
    else if (fall_edge) sout_r <= shift_r[0];
  end

  // Internal clock idles high, low in ST_LOW
  // Low ends on the rising tick, keeping the pin in step with the count
  wire sck_low = internal_clk && (st_r == sio_pkg::ST_LOW) && !int_rise;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) sck_r <= 1'b1;
    else sck_r <= !sck_low;
  end

  // Done flag: set wins over any clear in the same cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) done_r <= 1'b0;
    // Set after eighth bit; counted in both modes
    else if (last_rise) done_r <= 1'b1;
    else if (cpu_op.transfer_start_op) done_r <= 1'b0;
    // Cleared by interrupt taken or skip taken
    else if (cpu_op.irq_ack || skip_now) done_r <= 1'b0;
  end

  // CPU read-back paths
  // No path for read_shift_to_accs: shift_out is always visible
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_r <= 4'h0;
      skip_r <= 1'b0;
    end else begin
      if (cpu_op.read_mode_to_acc) acc_r <= mode_r;
      skip_r <= skip_now;
    end
  end

  // Pin function; external clock pin never driven
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_oe <= 1'b0;
      sout_oe <= 1'b0;
    end else begin
      sck_oe <= serial_pins && internal_clk;
      sout_oe <= serial_pins;
    end
  end

  // Outputs straight from their flip-flops
  assign acc_out = acc_r;
  assign shift_out = shift_r;
  assign skip_taken = skip_r;
  assign transfer_done_flag = done_r;
  assign sck_out = sck_r;
  assign sout_out = sout_r;
endmodule : clock_sync_serial_port

`default_nettype wire

/* File: sim/sio_asserts.sv */
// Port checker for the serial port.
// Assumes it is bound onto the port module below.
`timescale 1ns/1ps
`default_nettype none
module sio_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire sio_pkg::cpu_op_t cpu_op,
  input wire logic [2:0] shared_pin_in,
  input wire logic [3:0] acc_out,
  input wire logic [7:0] shift_out,
  input wire logic skip_taken,
  input wire logic transfer_done_flag,
  input wire logic [2:0] shared_input,
  input wire logic sck_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // CPU operations
  chk_load_split: assert property (cpu_op.load_shift_from_accs |=> shift_out ==
    {$past(cpu_op.reg_b), $past(cpu_op.acc_a)}) else $error("load split");
  chk_mode_back: assert property (cpu_op.write_mode_from_acc ##1 cpu_op.read_mode_to_acc
    |=> acc_out == $past(cpu_op.acc_a, 2)) else $error("mode read");
  chk_start_clear: assert property (cpu_op.transfer_start_op |=> !transfer_done_flag)
    else $error("start clear");
  chk_skip_clear: assert property (cpu_op.skip_if_transfer_done && transfer_done_flag
    |=> skip_taken && !transfer_done_flag) else $error("skip clear");
  chk_ack_clear: assert property (cpu_op.irq_ack |=> !transfer_done_flag)
    else $error("ack clear");
  // Link pins; the low bound assumes the bench's slowest divider
  chk_idle_high: assert property (transfer_done_flag |-> sck_out) else $error("idle");
  chk_low_bound: assert property ($fell(sck_out) |-> ##[1:80] sck_out) else $error("low");
  chk_pin_view: assert property (!$past(sys_rst, 3) |->
    shared_input == $past(shared_pin_in, 3)) else $error("pins");
  cover property (cpu_op.transfer_start_op);
  cover property ($rose(transfer_done_flag));
  cover property (skip_taken);
endmodule : sio_asserts
bind clock_sync_serial_port sio_asserts i_sio_asserts (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .cpu_op(cpu_op),
  .shared_pin_in(shared_pin_in),
  .acc_out(acc_out),
  .shift_out(shift_out),
  .skip_taken(skip_taken),
  .transfer_done_flag(transfer_done_flag),
  .shared_input(shared_input),
  .sck_out(sck_out)
);
`default_nettype wire

/* File: sim/sio_partner.sv */
// Far-side peer: swaps a byte, clocks the link on request.
// Assumes pin-level wires from the bench.
`timescale 1ns/1ps
`default_nettype none
module sio_partner (
  input wire logic [2:0] shared_pin_in,
  input wire logic ext_go,
  input wire logic receive_ready_line,
  input wire logic [7:0] tx,
  output logic ext_sck = 1'b1,
  output logic sin = 1'b1,
  output logic [7:0] rx = 8'h00
);
  logic [2:0] n = 3'h0;
  // send on fall, take on rise
  always @(negedge shared_pin_in[0]) begin
    sin <= tx[n];
    n <= n + 3'h1;
  end
  always @(posedge shared_pin_in[0]) rx <= {shared_pin_in[1], rx[7:1]};
  // idle high, eight pulses; only once ready line is low
  always @(posedge ext_go) begin
    wait (receive_ready_line == 1'b0);
    repeat (8) begin
      #40 ext_sck = 1'b0;
      #40 ext_sck = 1'b1;
    end
  end
endmodule : sio_partner
`default_nettype wire

/* File: sim/testbench.sv */
// Bench: mode read-back, then byte swaps at three clock settings.
// Assumes the port, its checker and sio_partner.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0, sys_rst = 1'b1, instr_clk_en = 1'b0, ext_go = 1'b0;
  logic skip_taken, transfer_done_flag, sck_out, sck_oe, sout_out, sout_oe, ext_sck, sin;
  logic [2:0] shared_input;
  logic receive_ready_line = 1'b1;
  logic [3:0] acc_out, modes[4] = '{4'h3, 4'h7, 4'h2, 4'hB};
  logic [7:0] shift_out, rx, tx = 8'h00, d = 8'h00;
  logic [15:0] e, exp_q[$];
  int bad_count = 0, num_checks = 0, seed = 1, cyc = 0, t;
  sio_pkg::cpu_op_t cpu_op = '0;
  wire [2:0] shared_pin_in = {sin, sout_oe ? sout_out : 1'b1, sck_oe ? sck_out : ext_sck};
  clock_sync_serial_port i_clock_sync_serial_port (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .instr_clk_en(instr_clk_en),
    .cpu_op(cpu_op),
    .shared_pin_in(shared_pin_in),
    .acc_out(acc_out),
    .shift_out(shift_out),
    .skip_taken(skip_taken),
    .transfer_done_flag(transfer_done_flag),
    .shared_input(shared_input),
    .sck_out(sck_out),
    .sck_oe(sck_oe),
    .sout_out(sout_out),
    .sout_oe(sout_oe)
  );
  sio_partner i_sio_partner (
    .shared_pin_in(shared_pin_in),
    .ext_go(ext_go),
    .receive_ready_line(receive_ready_line),
    .tx(tx),
    .ext_sck(ext_sck),
    .sin(sin),
    .rx(rx)
  );
  always #2 mclk = ~mclk;
  // Slow instruction clock keeps pin sync lag inside one phase
  always @(negedge mclk) instr_clk_en <= (cyc % 4 == 0);
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic op(logic [6:0] f, logic [7:0] ba = 8'h00);
    @(negedge mclk);
    cpu_op = {f, ba[3:0], ba[7:4]};
  endtask : op
  task automatic end_of_test();
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // Cycle ceiling
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  // Each completion takes the oldest note
  always @(posedge transfer_done_flag) begin
    #1 e = exp_q.pop_front();
    check("shift", shift_out, e[7:0]);
    check("peer", rx, e[15:8]);
  end
  initial begin
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    // Read back before each write; first read sees reset
    for (int i = 0; i < 17; i++) begin
      op(7'h20);
      op(7'h00);
      repeat (2) @(negedge mclk);
      check("mode", {acc_out, sck_oe, sout_oe}, {d[3:0], d[1] & d[0], d[1]});
      d = i;
      op(7'h40, d);
    end
    // Two internal rates, then external clock, then the slow internal rate again
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      tx = $random(seed);
      op(7'h40, {4'h0, modes[i]});
      op(7'h10, d);
      exp_q.push_back({d, tx});
      op(7'h04);
      receive_ready_line = 1'b0;
      op(7'h00);
      repeat (8) @(negedge mclk);
      ext_go = !modes[i][0];
      for (t = 9; t < 2000 && transfer_done_flag !== 1'b1; t++) @(negedge mclk);
      ext_go = 1'b0;
      receive_ready_line = 1'b1;
      check("done", {transfer_done_flag, sck_out}, 2'h3);
      if (modes[i][0]) check("rate", (t + 8) >> 5, modes[i][2] ? 4 : 8);
      op(i[0] ? 7'h01 : 7'h02);
      op(7'h00);
    end
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
